/* File: rtl/pchp_pkg.sv */
`default_nettype none

package pchp_pkg;
  localparam int          ADDR_W         = 11;
  localparam int          CCR_W          = 8;
  localparam logic [10:0] CCR_ADDR       = 11'h3F8;
  localparam logic [7:0]  CCR_RESET      = 8'h00;
  localparam int          CCR_INDEP_BIT  = 6;
  localparam int          IO_WIN_BITS    = 5;
  localparam logic [1:0]  ID_SEL         = 2'h3;
  localparam int          ID_SEL_LO      = 3;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          WAIT_MIN_NS    = 300;
  localparam int          WAIT_MIN_CYC   =
    (WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 4;

  typedef enum logic [2:0] {
    PCHP_IDLE = 3'b001,
    PCHP_BUSY = 3'b010,
    PCHP_DONE = 3'b100
  } pchp_wait_st_t;
endpackage

`default_nettype wire

/* File: rtl/pchp_stretch.sv */
`default_nettype none

// minimum-length counter for a stretched access
module pchp_stretch #(
  parameter int MIN_CYC = pchp_pkg::WAIT_MIN_CYC,
  parameter int CNT_W   = pchp_pkg::CNT_W
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output var  logic done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             run_r;
  logic             run_nxt;
  logic             done_r;
  logic             done_nxt;

  if (MIN_CYC < 1 || MIN_CYC >= (1 << CNT_W)) begin : g_chk
    $error("pchp_stretch: MIN_CYC does not fit the counter");
  end

  always_comb begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = done_r;
    if (abort) begin
      run_nxt  = 1'b0;
      done_nxt = 1'b0;
    end else if (start) begin
      cnt_nxt  = CNT_W'(MIN_CYC - 1);
      run_nxt  = 1'b1;
      done_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule // pchp_stretch

`default_nettype wire

/* File: rtl/pchp_host_port.sv */
`default_nettype none

module pchp_host_port #(
  parameter int IO_WIN_BITS  = pchp_pkg::IO_WIN_BITS,
  parameter int WAIT_MIN_CYC = pchp_pkg::WAIT_MIN_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        card_hw_reset_a,
  input  wire logic                        card_hw_reset_b,
  input  wire logic                        even_byte_card_enable_n,
  input  wire logic                        odd_byte_card_enable_n,
  input  wire logic                        reg_sel_n,
  input  wire logic                        oe_n,
  input  wire logic                        we_n,
  input  wire logic                        iord_n,
  input  wire logic                        iowr_n,
  input  wire logic [pchp_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic [pchp_pkg::ADDR_W-1:0] io_base,
  input  wire logic                        core_ready,
  input  wire logic                        core_word_ok,
  input  wire logic                        core_irq,
  output var  logic                        core_reset,
  output var  logic                        io_mode,
  output var  logic [7:0]                  card_config_reg,
  output var  logic                        io_rd_req,
  output var  logic                        io_wr_req,
  output var  logic                        wait_n,
  output var  logic                        inpack_n,
  output var  logic                        iois16_n,
  output var  logic                        ireq_n,
  output var  logic                        boot_rom_chip_select_n,
  output var  logic                        boot_rom_read_strobe_n,
  output var  logic                        boot_rom_upper_addr
);
  if (IO_WIN_BITS < pchp_pkg::ID_SEL_LO + 2 ||
      IO_WIN_BITS > pchp_pkg::ADDR_W - 1) begin : g_chk
    $error("pchp_host_port: IO_WIN_BITS out of range");
  end

  // port window compare, called once for hit, which feeds several decoders
  function automatic logic port_hit(
    input logic [pchp_pkg::ADDR_W-1:0] a,
    input logic [pchp_pkg::ADDR_W-1:0] base
  );
    port_hit = (a >> IO_WIN_BITS) == (base >> IO_WIN_BITS);
  endfunction

  logic hw_rst;
  logic ce_any;
  logic hit;
  logic indep;
  logic io_rd;
  logic io_wr;
  logic io_acc;
  logic ccr_wr;
  logic id_rd;
  logic cis_rd;
  logic rom_wr;
  logic stretch_done;

  assign hw_rst = rst | card_hw_reset_a | card_hw_reset_b;
  assign ce_any = ~even_byte_card_enable_n | ~odd_byte_card_enable_n;
  assign hit    = port_hit(addr, io_base);

  // mode and configuration
  logic       io_mode_r;
  logic       io_mode_nxt;
  logic [7:0] ccr_r;
  logic [7:0] ccr_nxt;
  logic       core_reset_r;

  assign ccr_wr = ce_any & ~reg_sel_n & ~we_n & iowr_n
                & (addr == pchp_pkg::CCR_ADDR);
  assign indep  = ccr_r[pchp_pkg::CCR_INDEP_BIT];

  always_comb begin
    ccr_nxt     = ccr_r;
    io_mode_nxt = io_mode_r;
    if (ccr_wr) begin
      ccr_nxt     = wdata;
      io_mode_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      ccr_r        <= pchp_pkg::CCR_RESET;
      io_mode_r    <= 1'b0;
      core_reset_r <= 1'b1;
    end else begin
      ccr_r        <= ccr_nxt;
      io_mode_r    <= io_mode_nxt;
      core_reset_r <= 1'b0;
    end
  end

  // I/O decode, dead until configured
  assign io_rd  = io_mode_r & ce_any & ~reg_sel_n & ~iord_n;
  assign io_wr  = io_mode_r & ce_any & ~reg_sel_n & ~iowr_n & we_n;
  assign io_acc = (io_rd | io_wr) & (hit | indep);

  // wait stretch
  pchp_pkg::pchp_wait_st_t st_r;
  pchp_pkg::pchp_wait_st_t st_nxt;
  logic wait_n_r;
  logic wait_n_nxt;
  logic rd_req_r;
  logic rd_req_nxt;
  logic wr_req_r;
  logic wr_req_nxt;

  pchp_stretch #(
    .MIN_CYC (WAIT_MIN_CYC),
    .CNT_W   (pchp_pkg::CNT_W)
  ) u_stretch (
    .clk   (clk),
    .rst   (hw_rst),
    .start (st_r == pchp_pkg::PCHP_IDLE && io_acc),
    .abort (!io_acc),
    .done  (stretch_done)
  );

  always_comb begin
    st_nxt     = st_r;
    wait_n_nxt = 1'b1;
    rd_req_nxt = 1'b0;
    wr_req_nxt = 1'b0;
    case (st_r)
      pchp_pkg::PCHP_IDLE: begin
        if (io_acc) begin
          st_nxt     = pchp_pkg::PCHP_BUSY;
          wait_n_nxt = 1'b0;
          rd_req_nxt = io_rd;
          wr_req_nxt = io_wr;
        end
      end
      pchp_pkg::PCHP_BUSY: begin
        if (!io_acc) begin
          st_nxt = pchp_pkg::PCHP_IDLE;
        end else if (stretch_done && core_ready) begin
          st_nxt = pchp_pkg::PCHP_DONE;
        end else begin
          wait_n_nxt = 1'b0;
        end
      end
      pchp_pkg::PCHP_DONE: begin
        if (!io_acc) begin
          st_nxt = pchp_pkg::PCHP_IDLE;
        end
      end
      default: begin
        st_nxt = pchp_pkg::PCHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      st_r     <= pchp_pkg::PCHP_IDLE;
      wait_n_r <= 1'b1;
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      wait_n_r <= wait_n_nxt;
      rd_req_r <= rd_req_nxt;
      wr_req_r <= wr_req_nxt;
    end
  end

  // response pins
  logic inpack_n_r;
  logic inpack_n_nxt;
  logic iois16_n_r;
  logic iois16_n_nxt;
  logic ireq_n_r;
  logic ireq_n_nxt;

  always_comb begin
    inpack_n_nxt = ~(io_rd & (hit | indep));
    iois16_n_nxt = 1'b1;
    ireq_n_nxt   = 1'b1;
    if (io_mode_r) begin
      iois16_n_nxt = ~(hit & core_word_ok);
      ireq_n_nxt   = ~core_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      inpack_n_r <= 1'b1;
      iois16_n_r <= 1'b1;
      ireq_n_r   <= 1'b1;
    end else begin
      inpack_n_r <= inpack_n_nxt;
      iois16_n_r <= iois16_n_nxt;
      ireq_n_r   <= ireq_n_nxt;
    end
  end

  // boot ROM strobes
  logic rom_cs_n_r;
  logic rom_cs_n_nxt;
  logic rom_rd_n_r;
  logic rom_rd_n_nxt;
  logic rom_hi_r;
  logic rom_hi_nxt;

  assign id_rd  = io_rd & hit & (addr[pchp_pkg::ID_SEL_LO +: 2]
                == pchp_pkg::ID_SEL);
  assign cis_rd = ce_any & ~reg_sel_n & ~oe_n;
  assign rom_wr = ce_any & ~reg_sel_n & ~we_n & ~iowr_n;

  always_comb begin
    rom_cs_n_nxt = ~(id_rd | cis_rd | rom_wr);
    rom_rd_n_nxt = ~(id_rd | cis_rd);
    rom_hi_nxt   = id_rd;
  end

  always_ff @(posedge clk) begin
    if (hw_rst) begin
      rom_cs_n_r <= 1'b1;
      rom_rd_n_r <= 1'b1;
      rom_hi_r   <= 1'b0;
    end else begin
      rom_cs_n_r <= rom_cs_n_nxt;
      rom_rd_n_r <= rom_rd_n_nxt;
      rom_hi_r   <= rom_hi_nxt;
    end
  end

  assign core_reset             = core_reset_r;
  assign io_mode                = io_mode_r;
  assign card_config_reg        = ccr_r;
  assign io_rd_req              = rd_req_r;
  assign io_wr_req              = wr_req_r;
  assign wait_n                 = wait_n_r;
  assign inpack_n               = inpack_n_r;
  assign iois16_n               = iois16_n_r;
  assign ireq_n                 = ireq_n_r;
  assign boot_rom_chip_select_n = rom_cs_n_r;
  assign boot_rom_read_strobe_n = rom_rd_n_r;
  assign boot_rom_upper_addr    = rom_hi_r;

  a_reset_clears_cfg: assert property (@(posedge clk)
    (card_hw_reset_a || rst) |=> (ccr_r == 8'h00 && !io_mode_r
                                  && core_reset_r))
    else $error("reset did not clear configuration");

  a_reset_b_ored: assert property (@(posedge clk)
    card_hw_reset_b |=> (!io_mode_r && core_reset_r && wait_n_r))
    else $error("second reset not acting as full reset");

  a_io_ignored: assert property (@(posedge clk) disable iff (hw_rst)
    (!io_mode_r && !ccr_wr) |=> (inpack_n_r && !rd_req_r && !wr_req_r))
    else $error("I/O strobe answered before configuration");

  a_wait_stretch: assert property (@(posedge clk) disable iff (hw_rst)
    (st_r == pchp_pkg::PCHP_IDLE && io_acc) ##1 (io_acc && !core_ready)
    [*2] |-> !wait_n_r)
    else $error("wait released before core ready");

  a_inpack_hit: assert property (@(posedge clk) disable iff (hw_rst)
    (io_mode_r && ce_any && !reg_sel_n && !iord_n && hit)
    |=> !inpack_n_r)
    else $error("input ack missing on own port read");

  a_inpack_indep: assert property (@(posedge clk) disable iff (hw_rst)
    (io_mode_r && indep && ce_any && !reg_sel_n && !iord_n)
    |=> !inpack_n_r)
    else $error("input ack missing in independent mode");

  a_width_word: assert property (@(posedge clk) disable iff (hw_rst)
    io_mode_r |=> (iois16_n_r == !($past(hit) && $past(core_word_ok))))
    else $error("16-bit indication wrong");

  a_mem_pins_high: assert property (@(posedge clk) disable iff (hw_rst)
    !io_mode_r |=> (iois16_n_r && ireq_n_r))
    else $error("memory mode pins not high");

  a_irq_follow: assert property (@(posedge clk) disable iff (hw_rst)
    io_mode_r |=> (ireq_n_r == !$past(core_irq)))
    else $error("interrupt pin does not follow request");

  a_rom_id_read: assert property (@(posedge clk) disable iff (hw_rst)
    id_rd |=> (!rom_cs_n_r && !rom_rd_n_r && rom_hi_r))
    else $error("ROM strobes wrong on ID read");

  a_mode_sticky: assert property (@(posedge clk)
    (io_mode_r && !hw_rst) |=> io_mode_r)
    else $error("I/O mode dropped without reset");
endmodule // pchp_host_port

`default_nettype wire

/* File: verification/pchp_host_model.sv */
`default_nettype none

// host socket side: card_hw_reset_a, card enables and access strobes
module pchp_host_model #(
  parameter int RST_HOLD_CYC = 10000,
  // enable hold kept short: the logic never times it
  parameter int CE_HOLD_CYC  = 20
) (
  input  wire logic        clk,
  input  wire logic        wait_n,
  output var  logic        card_hw_reset_a,
  output var  logic        even_byte_card_enable_n,
  output var  logic        odd_byte_card_enable_n,
  output var  logic        reg_sel_n,
  output var  logic        oe_n,
  output var  logic        we_n,
  output var  logic        iord_n,
  output var  logic        iowr_n,
  output var  logic [10:0] addr,
  output var  logic [7:0]  wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {card_hw_reset_a, even_byte_card_enable_n, odd_byte_card_enable_n} = 3'h7;
    {reg_sel_n, oe_n, we_n, iord_n, iowr_n} = 5'h1F;
    addr = 11'h000;
    wdata = 8'h00;
  end

  task automatic power_up();
    repeat (RST_HOLD_CYC) @(posedge clk);
    card_hw_reset_a <= 1'b0;
    repeat (CE_HOLD_CYC) @(posedge clk);
  endtask

  task automatic drive(input logic rd, wr, wen, input logic [10:0] a,
                       input logic [7:0] d);
    @(posedge clk);
    even_byte_card_enable_n <= 1'b0;
    reg_sel_n <= 1'b0;
    iord_n <= ~rd;
    iowr_n <= ~wr;
    oe_n <= rd | wr | wen;
    we_n <= ~wen;
    addr <= a;
    wdata <= d;
  endtask

  // hold strobes until wait is seen high at a falling edge, or for at most 50 cycles
  task automatic finish(output int n);
    n = 0;
    while (wait_n === 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    {even_byte_card_enable_n, reg_sel_n, oe_n, we_n, iord_n, iowr_n} <= 6'h3F;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
endmodule // pchp_host_model

`default_nettype wire

/* File: verification/pchp_host_port_control_bench.sv */
`default_nettype none

module pchp_host_port_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WMIN = pchp_pkg::WAIT_MIN_CYC;
  localparam int IB   = pchp_pkg::CCR_INDEP_BIT;
  localparam logic write_protect_switch_flag = 1'b1;

  logic clk, rst, card_hw_reset_a, card_hw_reset_b, reg_sel_n, oe_n, we_n;
  logic even_byte_card_enable_n, odd_byte_card_enable_n, iord_n, iowr_n;
  logic core_ready, core_word_ok, core_irq, core_reset, io_mode, m_mode;
  logic io_rd_req, io_wr_req, wait_n, inpack_n, iois16_n, ireq_n;
  logic boot_rom_chip_select_n, boot_rom_read_strobe_n, boot_rom_upper_addr;
  logic [10:0] addr, io_base;
  logic [7:0]  wdata, card_config_reg, m_ccr;
  logic [17:0] q[$];
  int          n_mismatch = 0;
  int          n_compared = 0;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pchp_host_port dut (.clk, .rst, .card_hw_reset_a, .card_hw_reset_b,
    .even_byte_card_enable_n, .odd_byte_card_enable_n, .reg_sel_n, .oe_n,
    .we_n, .iord_n, .iowr_n, .addr, .wdata, .io_base, .core_ready,
    .core_word_ok, .core_irq, .core_reset, .io_mode, .card_config_reg,
    .io_rd_req, .io_wr_req, .wait_n, .inpack_n, .iois16_n, .ireq_n,
    .boot_rom_chip_select_n, .boot_rom_read_strobe_n, .boot_rom_upper_addr);

  pchp_host_model host (.clk, .wait_n, .card_hw_reset_a,
    .even_byte_card_enable_n, .odd_byte_card_enable_n, .reg_sel_n, .oe_n,
    .we_n, .iord_n, .iowr_n, .addr, .wdata);

  always @(posedge clk) core_ready <= ($urandom % 4) != 0;

  // md: mode in force at the edge that samples the strobes
  function automatic logic [17:0] expv(input logic cr, rd, wr, wen, md,
                                       input logic [10:0] a);
    logic win, hit, id, cis;
    win = a[10:5] == io_base[10:5];
    hit = md & (win | m_ccr[IB]);
    id = rd & hit & win & (a[4:3] == 2'h3);
    cis = ~rd & ~wr & ~wen;
    if (cr) return {8'h00, 10'h07D};
    return {m_ccr, m_mode, rd & hit, wr & ~wen & hit, ~(rd & hit),
            ~(md & win & core_word_ok), ~(md & core_irq),
            ~(id | cis | (wr & wen)), ~(id | cis), id, 1'b0};
  endfunction

  always @(negedge clk) begin
    logic [17:0] e, s;
    if (q.size() != 0) begin
      e = q.pop_front();
      s = {card_config_reg, io_mode, io_rd_req, io_wr_req, inpack_n,
           iois16_n, ireq_n, boot_rom_chip_select_n,
           boot_rom_read_strobe_n, boot_rom_upper_addr, core_reset};
      n_compared++;
      if (s !== e) begin
        n_mismatch++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, s);
      end
    end
  end

  task automatic note(input logic cr, rd, wr, wen, md,
                      input logic [10:0] a);
    @(posedge clk);
    q.push_back(expv(cr, rd, wr, wen, md, a));
    @(negedge clk);
  endtask

  task automatic acc(input logic rd, wr, wen, input logic [10:0] a,
                     input logic [7:0] d);
    int n;
    logic h, pm;
    host.drive(rd, wr, wen, a, d);
    pm = m_mode;
    if (wen && !wr && a == pchp_pkg::CCR_ADDR) begin
      m_ccr = d;
      m_mode = 1'b1;
    end
    h = m_mode & ((a[10:5] == io_base[10:5]) | m_ccr[IB]);
    note(1'b0, rd, wr, wen, pm, a);
    host.finish(n);
    if (rd && (h || !m_mode)) begin
      n_compared++;
      if (h ? (n < WMIN || n > 40) : n != 0) begin
        n_mismatch++;
        $display("ERROR t=%0t exp=%h got=%h", $time, WMIN, n);
      end
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    {rst, card_hw_reset_b, core_word_ok, core_irq} = 4'hB;
    m_ccr = 8'h00;
    m_mode = 1'b0;
    void'($urandom(78));
    io_base = {6'($urandom % 30), 5'h00};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    note(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, addr);
    host.power_up();
    acc(1'b1, 1'b0, 1'b0, io_base + 11'h004, 8'h00);
    acc(1'b0, 1'b0, 1'b0, 11'h000, 8'h00);
    acc(1'b0, 1'b1, 1'b0, io_base, 8'h5A);
    acc(1'b0, 1'b0, 1'b1, pchp_pkg::CCR_ADDR, 8'($urandom) & 8'hBF);
    for (int i = 0; i < 8; i++) begin
      core_word_ok <= 1'($urandom);
      core_irq <= 1'($urandom);
      acc(1'b1, 1'b0, 1'b0, io_base | 11'((i % 4) * 8 + $urandom % 8),
          8'h00);
      acc(1'b0, 1'b1, 1'b0, io_base | 11'($urandom % 32), 8'($urandom));
    end
    acc(1'b1, 1'b0, 1'b0, io_base ^ 11'h400, 8'h00);
    if (write_protect_switch_flag) begin
      acc(1'b0, 1'b1, 1'b1, io_base, 8'hA5);
    end
    acc(1'b0, 1'b0, 1'b1, pchp_pkg::CCR_ADDR, 8'(1 << IB));
    acc(1'b1, 1'b0, 1'b0, io_base ^ 11'h400, 8'h00);
    @(posedge clk) card_hw_reset_b <= 1'b1;
    note(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, addr);
    @(posedge clk) card_hw_reset_b <= 1'b0;
    m_ccr = 8'h00;
    m_mode = 1'b0;
    acc(1'b1, 1'b0, 1'b0, io_base, 8'h00);
    end_of_test();
  end
endmodule // pchp_host_port_control_bench

`default_nettype wire
